//--- hdl/swrs_pkg.sv
// How it works
// - Sleep starts only after two sleep writes
// - First write turns forward reset into sleep
// - Second write ramps down; forward reset, not the write, stops forwarded clocks
// - Ramp-down runs ramp-up states and durations in reverse, then 16 nominal cycles
// - Lock intervals: 4108 and 8205 core cycles
// - Sleep entry: keep base, fetch control 3
// - Keep enables; wake on unmasked interrupt only
// - Wake interrupts arrive asynchronously
// - Wake: ramp up, then 8192-cycle array init
// - Sleep exit skips ROM, fetches base+0x780
// - Forwarded clocks stopped under forward reset
// - Allow 264 cycles to capture framing clock
// - Wait 264 cycles before first command
// - System reset in run ramps down
// - Warm hold: clear base and fetch control
// - Hold until reset release, then ramp up
// - Assert ROM enable, self-test, ROM load
// - Drop ROM enable, restart clocks, wait 264
// - Self-test covers caches, tags, branch table
// - Board cache off until firmware enables
package swrs_pkg;

  localparam int CNT_W = 16;
  localparam int BASE_W = 32;

  // Timing counts, core clock cycles
  localparam int HALF_LOCK_CYCLES = 4108;
  localparam int FULL_LOCK_CYCLES = 8205;
  localparam int ARRAY_INIT_CYCLES = 8192;
  localparam int NOMINAL_CYCLES = 16;
  localparam int CAPTURE_CYCLES = 264;
  localparam int CMD_GAP_CYCLES = 264;

  // Reset values and fetch offset
  localparam logic [BASE_W-1:0] FETCH_OFFSET = 32'h0000_0780;
  localparam logic [1:0] IFC_SLEEP = 2'h3;
  localparam logic [1:0] IFC_CLEAR = 2'h0;

  // PLL divisor selections
  localparam logic [1:0] DIV_NOMINAL = 2'h0;
  localparam logic [1:0] DIV_HALF = 2'h1;
  localparam logic [1:0] DIV_FULL = 2'h2;

  // Array mask bit positions for self-test
  localparam int ARR_ICACHE = 0;
  localparam int ARR_ITAG = 1;
  localparam int ARR_DCACHE = 2;
  localparam int ARR_DTAG = 3;
  localparam int ARR_DUPTAG = 4;
  localparam int ARR_BHT = 5;
  localparam int ARR_W = 6;

  // Synchroniser bit positions
  localparam int SY_FWD = 0;
  localparam int SY_SYSRST_N = 1;
  localparam int SY_FRAME = 2;
  localparam int SY_CLK_IRQ = 3;
  localparam int SY_DEV_IRQ = 4;
  localparam int SY_W = 5;

  typedef enum logic [15:0] {
    SWRS_RUN        = 16'h0001,
    SWRS_RAMP_DOWN_FIRST      = 16'h0002,
    SWRS_RAMP_DOWN_SECOND      = 16'h0004,
    SWRS_RAMP_DOWN_THIRD      = 16'h0008,
    SWRS_WAIT_IRQ   = 16'h0010,
    SWRS_WAIT_RESET = 16'h0020,
    SWRS_RAMP1      = 16'h0040,
    SWRS_RAMP2      = 16'h0080,
    SWRS_WAIT_FWD0  = 16'h0100,
    SWRS_SELFTEST   = 16'h0200,
    SWRS_ROMLOAD    = 16'h0400,
    SWRS_WAIT_FWD1  = 16'h0800,
    SWRS_CAPTURE    = 16'h1000,
    SWRS_ARRAY_INIT = 16'h2000,
    SWRS_CMD_WAIT   = 16'h4000,
    SWRS_FAULT      = 16'h8000
  } swrs_state_t;

  // Firmware-side control strobes
  typedef struct packed {
    logic sleep_write;
    logic base_write;
    logic [BASE_W-1:0] base_data;
    logic board_cache_write;
    logic board_cache_data;
    logic clock_irq_enable;
    logic device_irq_enable;
  } swrs_fw_t;

endpackage

//--- hdl/swrs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module swrs_sync
  import swrs_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } swrs_sync_st_t;

  swrs_sync_st_t r;
  swrs_sync_st_t next_r;

  always_comb
  begin
    next_r.meta = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign sync_out = r.stable;

endmodule
`default_nettype wire

//--- hdl/swrs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module swrs_sequencer
  import swrs_pkg::*;
#(
  parameter int HALF_LOCK = HALF_LOCK_CYCLES,
  parameter int FULL_LOCK = FULL_LOCK_CYCLES,
  parameter int ARRAY_INIT = ARRAY_INIT_CYCLES,
  parameter int NOMINAL = NOMINAL_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // System pins, asynchronous
  input wire logic clock_forward_reset,
  input wire logic system_reset_n,
  input wire logic framing_clock,
  input wire logic clock_irq,
  input wire logic device_irq,
  // Firmware controls
  input wire swrs_fw_t fw,
  // Self-test and ROM load engines
  input wire logic selftest_done,
  input wire logic rom_load_done,
  output logic selftest_start,
  output logic [ARR_W-1:0] selftest_arrays,
  output logic rom_load_start,
  output logic short_array_init,
  // PLL and pins
  output logic [1:0] pll_div_sel,
  output logic boot_rom_output_enable_n,
  output logic fwd_clocks_run,
  // Processor state
  output logic [BASE_W-1:0] privileged_code_base,
  output logic [1:0] instr_fetch_control,
  output logic float_enable_bit,
  output logic board_cache_enable,
  output logic config_chain_clear,
  output logic cmd_enable,
  output logic fetch_enable,
  output logic [BASE_W-1:0] fetch_addr,
  output swrs_state_t seq_state
);

  typedef struct packed {
    swrs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic armed;
    logic warm;
    logic fwd_prev;
    logic frame_prev;
    logic [BASE_W-1:0] base;
    logic [1:0] ifc;
    logic fpe;
    logic bcache;
    logic chain_clr;
    logic rom_oe_n;
    logic clk_run;
    logic cmd_en;
    logic fetch_en;
    logic [BASE_W-1:0] faddr;
    logic st_go;
    logic rom_go;
  } swrs_seq_st_t;

  swrs_seq_st_t r;
  swrs_seq_st_t next_r;
  logic [SY_W-1:0] pins_s;
  logic fwd_s;
  logic sysrst_n_s;
  logic frame_s;
  logic wake;
  logic fwd_fall;
  logic frame_rise;

  function automatic logic [CNT_W-1:0] span(input int cycles);
    span = CNT_W'(cycles - 1);
  endfunction

  function automatic logic [1:0] div_for(input swrs_state_t s);
    case (s)
      SWRS_RAMP1, SWRS_RAMP_DOWN_SECOND: div_for = DIV_HALF;
      SWRS_RAMP_DOWN_THIRD, SWRS_WAIT_IRQ, SWRS_WAIT_RESET: div_for = DIV_NOMINAL;
      default: div_for = DIV_FULL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  swrs_sync #(
    .WIDTH(SY_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({device_irq, clock_irq, framing_clock, system_reset_n,
               clock_forward_reset}),
    .sync_out(pins_s)
  );

  assign fwd_s = pins_s[SY_FWD];
  assign sysrst_n_s = pins_s[SY_SYSRST_N];
  assign frame_s = pins_s[SY_FRAME];
  // Enables stay as firmware left them through sleep
  assign wake = (pins_s[SY_CLK_IRQ] & fw.clock_irq_enable) |
                (pins_s[SY_DEV_IRQ] & fw.device_irq_enable);
  assign fwd_fall = r.fwd_prev & ~fwd_s;
  assign frame_rise = ~r.frame_prev & frame_s;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    next_r = r;
    next_r.fwd_prev = fwd_s;
    next_r.frame_prev = frame_s;
    next_r.st_go = 1'b0;
    next_r.rom_go = 1'b0;
    next_r.chain_clr = 1'b0;
    // Forwarded clocks stop the cycle after forward reset is seen
    next_r.clk_run = r.clk_run & ~fwd_s;
    if (r.cnt != '0)
      next_r.cnt = r.cnt - CNT_W'(1);
    case (r.st)
      SWRS_RUN:
      begin
        if (!sysrst_n_s)
        begin
          next_r.st = SWRS_RAMP_DOWN_FIRST;
          next_r.warm = 1'b1;
          next_r.armed = 1'b0;
          next_r.cmd_en = 1'b0;
          next_r.fetch_en = 1'b0;
          next_r.cnt = span(FULL_LOCK);
        end
        else if (fw.sleep_write && r.armed)
        begin
          next_r.st = SWRS_RAMP_DOWN_FIRST;
          next_r.warm = 1'b0;
          next_r.armed = 1'b0;
          next_r.cmd_en = 1'b0;
          next_r.fetch_en = 1'b0;
          next_r.cnt = span(FULL_LOCK);
        end
        else if (fw.sleep_write)
          next_r.armed = 1'b1;
        else if (fwd_s && !r.armed)
        begin
          // Armed sleep swallows forward reset instead of faulting
          next_r.st = SWRS_FAULT;
          // Fault exit needs two releases, so it takes the warm edge rule
          next_r.warm = 1'b1;
          next_r.ifc = IFC_SLEEP;
          next_r.fpe = 1'b1;
          next_r.bcache = 1'b0;
          next_r.chain_clr = 1'b1;
          next_r.cmd_en = 1'b0;
          next_r.fetch_en = 1'b0;
        end
        // Firmware re-enables the board cache only once running
        if (fw.board_cache_write)
          next_r.bcache = fw.board_cache_data;
        if (fw.base_write)
          next_r.base = fw.base_data;
      end
      SWRS_RAMP_DOWN_FIRST:
        if (r.cnt == '0)
        begin
          next_r.st = SWRS_RAMP_DOWN_SECOND;
          next_r.cnt = span(HALF_LOCK);
        end
      SWRS_RAMP_DOWN_SECOND:
        if (r.cnt == '0)
        begin
          next_r.st = SWRS_RAMP_DOWN_THIRD;
          next_r.cnt = span(NOMINAL);
        end
      SWRS_RAMP_DOWN_THIRD:
        if (r.cnt == '0)
        begin
          next_r.fpe = 1'b1;
          next_r.bcache = 1'b0;
          next_r.chain_clr = 1'b1;
          if (r.warm)
          begin
            next_r.st = SWRS_WAIT_RESET;
            next_r.base = '0;
            next_r.ifc = IFC_CLEAR;
          end
          else
          begin
            next_r.st = SWRS_WAIT_IRQ;
            next_r.ifc = IFC_SLEEP;
          end
        end
      SWRS_WAIT_IRQ:
        if (wake)
        begin
          next_r.st = SWRS_RAMP1;
          next_r.cnt = span(HALF_LOCK);
        end
      SWRS_WAIT_RESET:
        if (sysrst_n_s)
        begin
          next_r.st = SWRS_RAMP1;
          next_r.cnt = span(HALF_LOCK);
        end
      SWRS_RAMP1:
        if (r.cnt == '0)
        begin
          next_r.st = SWRS_RAMP2;
          next_r.cnt = span(FULL_LOCK);
        end
      SWRS_RAMP2:
        if (r.cnt == '0)
        begin
          if (r.warm)
          begin
            // Forward reset must already be up here
            next_r.st = SWRS_WAIT_FWD0;
            next_r.rom_oe_n = 1'b0;
          end
          else
          begin
            next_r.st = SWRS_ARRAY_INIT;
            next_r.cnt = span(ARRAY_INIT);
          end
        end
      SWRS_WAIT_FWD0:
        if (fwd_fall)
        begin
          next_r.st = SWRS_SELFTEST;
          next_r.st_go = 1'b1;
        end
      SWRS_SELFTEST:
        if (selftest_done)
        begin
          next_r.st = SWRS_ROMLOAD;
          next_r.rom_go = 1'b1;
        end
      SWRS_ROMLOAD:
        if (rom_load_done)
        begin
          next_r.st = SWRS_WAIT_FWD1;
          next_r.rom_oe_n = 1'b1;
        end
      SWRS_ARRAY_INIT:
        if (r.cnt == '0)
          next_r.st = SWRS_WAIT_FWD1;
      SWRS_FAULT:
        if (fwd_fall)
          next_r.st = SWRS_WAIT_FWD1;
      SWRS_WAIT_FWD1:
        // Sleep release may come during the ramp, so level counts there
        if ((!r.warm && !fwd_s && !r.fwd_prev) || fwd_fall)
        begin
          next_r.st = SWRS_CAPTURE;
          next_r.cnt = span(CAPTURE_CYCLES);
        end
      SWRS_CAPTURE:
        if (r.cnt == '0 && frame_rise && !fwd_s)
        begin
          next_r.st = SWRS_CMD_WAIT;
          next_r.clk_run = 1'b1;
          next_r.cnt = span(CMD_GAP_CYCLES);
        end
      SWRS_CMD_WAIT:
        if (r.cnt == '0)
        begin
          next_r.st = SWRS_RUN;
          next_r.cmd_en = 1'b1;
          next_r.fetch_en = 1'b1;
          next_r.faddr = r.base + FETCH_OFFSET;
          next_r.warm = 1'b0;
        end
      default:
        next_r.st = SWRS_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= SWRS_WAIT_RESET;
      r.warm <= 1'b1;
      r.rom_oe_n <= 1'b1;
      r.fpe <= 1'b1;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign seq_state = r.st;
  assign pll_div_sel = div_for(r.st);
  assign selftest_start = r.st_go;
  assign rom_load_start = r.rom_go;
  assign selftest_arrays = ARR_W'((1 << ARR_ICACHE) | (1 << ARR_ITAG) |
    (1 << ARR_DCACHE) | (1 << ARR_DTAG) | (1 << ARR_DUPTAG) | (1 << ARR_BHT));
  assign short_array_init = (r.st == SWRS_ARRAY_INIT);
  assign boot_rom_output_enable_n = r.rom_oe_n;
  assign fwd_clocks_run = r.clk_run;
  assign privileged_code_base = r.base;
  assign instr_fetch_control = r.ifc;
  assign float_enable_bit = r.fpe;
  assign board_cache_enable = r.bcache;
  assign config_chain_clear = r.chain_clr;
  assign cmd_enable = r.cmd_en;
  assign fetch_enable = r.fetch_en;
  assign fetch_addr = r.faddr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_sleep_two_writes: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == SWRS_RUN && next_r.st == SWRS_RAMP_DOWN_FIRST && sysrst_n_s) |-> r.armed)
    else $error("sleep began without a prior arming write");

  a_no_fault_armed: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == SWRS_RUN && r.armed && fwd_s && sysrst_n_s) |=> r.st != SWRS_FAULT)
    else $error("fault reset taken while sleep armed");

  a_clocks_stopped: assert property (@(posedge clk_sys) disable iff (rst)
    $past(fwd_s) && fwd_s |-> !fwd_clocks_run)
    else $error("forwarded clocks run under forward reset");

  a_sleep_regs: assert property (@(posedge clk_sys) disable iff (rst)
    r.st == SWRS_WAIT_IRQ |-> instr_fetch_control == IFC_SLEEP && float_enable_bit
      && !board_cache_enable && $stable(privileged_code_base))
    else $error("sleep wait entry state wrong");

  a_warm_regs: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(r.st == SWRS_WAIT_RESET) |-> privileged_code_base == '0
      && instr_fetch_control == IFC_CLEAR && float_enable_bit && !board_cache_enable)
    else $error("warm hold entry state wrong");

  a_reset_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == SWRS_WAIT_RESET && !sysrst_n_s) |=> r.st == SWRS_WAIT_RESET)
    else $error("left warm hold while reset asserted");

  a_wake_needs_irq: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == SWRS_WAIT_IRQ && !wake) |=> r.st == SWRS_WAIT_IRQ)
    else $error("left sleep wait without unmasked interrupt");

  a_rom_enable: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == SWRS_WAIT_FWD0 || r.st == SWRS_SELFTEST || r.st == SWRS_ROMLOAD)
      |-> !boot_rom_output_enable_n)
    else $error("boot ROM enable not asserted in load phase");

  a_cmd_gap: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(r.st == SWRS_CMD_WAIT) |-> ##263 (r.st == SWRS_CMD_WAIT && !cmd_enable)
      ##1 cmd_enable)
    else $error("first command gap not 264 cycles");

  a_fetch_addr: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(fetch_enable) |-> fetch_addr == privileged_code_base + FETCH_OFFSET)
    else $error("fetch address not base plus offset");

endmodule
`default_nettype wire

//--- testbench/swrs_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
module swrs_chipset_model
  import swrs_pkg::*;
(
  // Core clock, for reset timing only
  input wire logic clk_sys,
  // Pins toward the sequencer
  output logic clock_forward_reset,
  output logic system_reset_n,
  output logic framing_clock,
  output logic clock_irq,
  output logic device_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Forward reset held from power-on so the first bring-up finds it high
  initial
  begin
    clock_forward_reset = 1'b1;
    system_reset_n = 1'b0;
    clock_irq = 1'b0;
    device_irq = 1'b0;
    framing_clock = 1'b0;
    #17.3;
    forever #62.5 framing_clock = ~framing_clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Forward reset and interrupts move on frame edges, unrelated in phase to the core clock; system reset on the core clock
  task automatic fwd(input logic v);
    @(posedge framing_clock);
    clock_forward_reset = v;
  endtask

  task automatic sysrst(input logic v);
    @(posedge clk_sys);
    system_reset_n <= v;
  endtask

  // Release comes two frames after the interrupt, not one, for margin
  task automatic wake(input logic dev);
    @(posedge framing_clock);
    clock_irq = ~dev;
    device_irq = dev;
    repeat (2) @(posedge framing_clock);
    clock_forward_reset = 1'b0;
    @(posedge framing_clock);
    clock_irq = 1'b0;
    device_irq = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_swrs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_swrs_sequencer
  import swrs_pkg::*;
;
  // Shortened counts keep the run brief
  localparam int HL = 8;
  localparam int FL = 16;
  localparam int AI = 32;
  localparam int NM = 4;

  logic clk_sys;
  logic rst;
  wire logic clock_forward_reset;
  wire logic system_reset_n;
  wire logic framing_clock;
  wire logic clock_irq;
  wire logic device_irq;
  swrs_fw_t fw;
  logic selftest_done;
  logic rom_load_done;
  logic selftest_start;
  logic [ARR_W-1:0] selftest_arrays;
  logic rom_load_start;
  logic short_array_init;
  logic [1:0] pll_div_sel;
  logic boot_rom_output_enable_n;
  logic fwd_clocks_run;
  logic [BASE_W-1:0] privileged_code_base;
  logic [1:0] instr_fetch_control;
  logic float_enable_bit;
  logic board_cache_enable;
  logic config_chain_clear;
  logic cmd_enable;
  logic fetch_enable;
  logic [BASE_W-1:0] fetch_addr;
  swrs_state_t seq_state;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] base;

  swrs_chipset_model i_swrs_chipset_model (
    .clk_sys(clk_sys), .clock_forward_reset(clock_forward_reset),
    .system_reset_n(system_reset_n), .framing_clock(framing_clock),
    .clock_irq(clock_irq), .device_irq(device_irq));

  swrs_sequencer #(.HALF_LOCK(HL), .FULL_LOCK(FL), .ARRAY_INIT(AI), .NOMINAL(NM))
  i_swrs_sequencer (
    .clk_sys(clk_sys), .rst(rst), .clock_forward_reset(clock_forward_reset),
    .system_reset_n(system_reset_n), .framing_clock(framing_clock),
    .clock_irq(clock_irq), .device_irq(device_irq), .fw(fw),
    .selftest_done(selftest_done), .rom_load_done(rom_load_done),
    .selftest_start(selftest_start), .selftest_arrays(selftest_arrays),
    .rom_load_start(rom_load_start), .short_array_init(short_array_init),
    .pll_div_sel(pll_div_sel), .boot_rom_output_enable_n(boot_rom_output_enable_n),
    .fwd_clocks_run(fwd_clocks_run), .privileged_code_base(privileged_code_base),
    .instr_fetch_control(instr_fetch_control), .float_enable_bit(float_enable_bit),
    .board_cache_enable(board_cache_enable), .config_chain_clear(config_chain_clear),
    .cmd_enable(cmd_enable), .fetch_enable(fetch_enable), .fetch_addr(fetch_addr),
    .seq_state(seq_state));

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_state(input swrs_state_t s);
    for (int i = 0; i < 3000 && seq_state !== s; i++)
      @(posedge clk_sys);
    chk(32'(seq_state), 32'(s));
  endtask

  // Counts the sampled cycles spent in one state
  task automatic track(input swrs_state_t s, input logic [1:0] div, output int c);
    wait_state(s);
    chk(32'(pll_div_sel), 32'(div));
    c = 0;
    while (seq_state === s && c < 20000)
    begin
      c++;
      @(posedge clk_sys);
    end
  endtask

  task automatic pulse(input int which);
    selftest_done <= (which == 0);
    rom_load_done <= (which != 0);
    @(posedge clk_sys);
    selftest_done <= 1'b0;
    rom_load_done <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic ramp_down();
    int c;
    wait_state(SWRS_RAMP_DOWN_FIRST);
    chk(32'(cmd_enable), 32'h0);
    track(SWRS_RAMP_DOWN_FIRST, DIV_FULL, c);
    chk(c, FL);
    track(SWRS_RAMP_DOWN_SECOND, DIV_HALF, c);
    chk(c, HL);
    track(SWRS_RAMP_DOWN_THIRD, DIV_NOMINAL, c);
    chk(c, NM);
  endtask

  task automatic tail();
    int c;
    track(SWRS_WAIT_FWD1, DIV_FULL, c);
    chk(32'(fwd_clocks_run), 32'h0);
    track(SWRS_CAPTURE, DIV_FULL, c);
    chk(32'(c >= CAPTURE_CYCLES), 32'h1);
    chk(32'(fwd_clocks_run), 32'h1);
    chk(32'(cmd_enable), 32'h0);
    track(SWRS_CMD_WAIT, DIV_FULL, c);
    chk(c, CMD_GAP_CYCLES);
    chk(32'(cmd_enable & fetch_enable), 32'h1);
  endtask

  task automatic warm_up();
    int c;
    i_swrs_chipset_model.sysrst(1'b1);
    track(SWRS_WAIT_RESET, DIV_NOMINAL, c);
    track(SWRS_RAMP1, DIV_HALF, c);
    chk(c, HL);
    track(SWRS_RAMP2, DIV_FULL, c);
    chk(c, FL);
    wait_state(SWRS_WAIT_FWD0);
    chk(32'(boot_rom_output_enable_n), 32'h0);
    chk(32'(fwd_clocks_run), 32'h0);
    i_swrs_chipset_model.fwd(1'b0);
    wait_state(SWRS_SELFTEST);
    chk(32'(selftest_start), 32'h1);
    chk(32'(selftest_arrays), 32'h3F);
    pulse(0);
    wait_state(SWRS_ROMLOAD);
    chk(32'(rom_load_start), 32'h1);
    pulse(1);
    wait_state(SWRS_WAIT_FWD1);
    chk(32'(boot_rom_output_enable_n), 32'h1);
    i_swrs_chipset_model.fwd(1'b1);
    i_swrs_chipset_model.fwd(1'b0);
    tail();
  endtask

  task automatic sleep_round(input logic dev);
    int c;
    // The enable of the silent line may be on; it must not wake
    fw.clock_irq_enable <= dev & 1'($urandom);
    fw.device_irq_enable <= ~dev & 1'($urandom);
    fw.sleep_write <= 1'b1;
    @(posedge clk_sys);
    fw.sleep_write <= 1'b0;
    i_swrs_chipset_model.fwd(1'b1);
    repeat ($urandom_range(4, 12)) @(posedge clk_sys);
    chk(32'(seq_state), 32'(SWRS_RUN));
    fw.sleep_write <= 1'b1;
    @(posedge clk_sys);
    fw.sleep_write <= 1'b0;
    @(posedge clk_sys);
    chk(32'(seq_state), 32'(SWRS_RAMP_DOWN_FIRST));
    ramp_down();
    wait_state(SWRS_WAIT_IRQ);
    chk(32'(config_chain_clear), 32'h1);
    chk(privileged_code_base, base);
    chk(32'(instr_fetch_control), 32'(IFC_SLEEP));
    chk(32'({float_enable_bit, board_cache_enable}), 32'h2);
    fork
      i_swrs_chipset_model.wake(dev);
    join_none
    wait (clock_irq || device_irq);
    repeat (10) @(posedge clk_sys);
    chk(32'(seq_state), 32'(SWRS_WAIT_IRQ));
    chk(32'(fwd_clocks_run), 32'h0);
    fw.clock_irq_enable <= fw.clock_irq_enable | ~dev;
    fw.device_irq_enable <= fw.device_irq_enable | dev;
    track(SWRS_WAIT_IRQ, DIV_NOMINAL, c);
    chk(32'(c < 8), 32'h1);
    track(SWRS_RAMP1, DIV_HALF, c);
    chk(c, HL);
    track(SWRS_RAMP2, DIV_FULL, c);
    chk(c, FL);
    chk(32'(short_array_init), 32'h1);
    track(SWRS_ARRAY_INIT, DIV_FULL, c);
    chk(c, AI);
    tail();
    chk(fetch_addr, base + FETCH_OFFSET);
    chk(32'(board_cache_enable), 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    fw = '0;
    selftest_done = 1'b0;
    rom_load_done = 1'b0;
    void'($urandom(32'h3622));
    base = $urandom & 32'hFFFF_F000;
    repeat (6) @(posedge clk_sys);
    chk(32'(seq_state), 32'(SWRS_WAIT_RESET));
    chk(32'({float_enable_bit, boot_rom_output_enable_n}), 32'h3);
    rst <= 1'b0;
    warm_up();
    chk(fetch_addr, FETCH_OFFSET);
    fw.base_write <= 1'b1;
    fw.base_data <= base;
    fw.board_cache_write <= 1'b1;
    fw.board_cache_data <= 1'b1;
    @(posedge clk_sys);
    fw.base_write <= 1'b0;
    fw.board_cache_write <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(privileged_code_base, base);
    chk(32'(board_cache_enable), 32'h1);
    for (int d = 0; d < 2; d++)
      sleep_round(d[0]);
    i_swrs_chipset_model.sysrst(1'b0);
    ramp_down();
    wait_state(SWRS_WAIT_RESET);
    chk(32'(config_chain_clear), 32'h1);
    chk(privileged_code_base, 32'h0);
    chk(32'(instr_fetch_control), 32'(IFC_CLEAR));
    chk(32'({float_enable_bit, board_cache_enable}), 32'h2);
    i_swrs_chipset_model.fwd(1'b1);
    warm_up();
    chk(fetch_addr, FETCH_OFFSET);
    // Unarmed forward reset: fault path, two releases, no self-test
    i_swrs_chipset_model.fwd(1'b1);
    wait_state(SWRS_FAULT);
    chk(32'({config_chain_clear, instr_fetch_control}), 32'h7);
    chk(32'({float_enable_bit, board_cache_enable, cmd_enable}), 32'h4);
    i_swrs_chipset_model.fwd(1'b0);
    wait_state(SWRS_WAIT_FWD1);
    i_swrs_chipset_model.fwd(1'b1);
    i_swrs_chipset_model.fwd(1'b0);
    tail();
    chk(fetch_addr, FETCH_OFFSET);
    close_out();
  end

  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
